// [rtl/cfg_header_tail.sv]
// Configuration header tail register bank of the link function
// Summary of operation
// - Extension window pointer bits 31-11 read-only, reset zero, writes ignored.
// - Bits 10-4 of extension base read zero: 2-Kbyte window.
// - Bit 3 of extension base reads zero: non-prefetchable.
// - Bits 2-1 of extension base read zero: 32-bit anywhere.
// - Bit 0 of extension base reads zero: memory space.
// - Subsystem ident loaded from EEPROM or access register, not config writes.
// - Subsystem device ident in 31-16, vendor ident in 15-0, reset zero.
// - Capabilities pointer at 34h always reads 44h.
// - Power management block lives at doublewords 44h and 48h.
// - Pin byte reads 01h for line A, 02h for line B.
// - When tie select bit is set, pin byte reads 01h.
// - Interrupt route word resets to 0200h, pin byte reports line B.
// - With serial ROM present, latency hints load from ROM after reset.
// - Without serial ROM, latency hints read 0403h.
// - Access interval hint bits 15-8, minimum grant bits 7-0, host read-only.
// - Host controller control word at 40h reads 0000h.
`timescale 1ns/1ns
module cfg_header_tail
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Configuration access, dword aligned address
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  output logic             pm_select,
  // Device-side update paths
  input  wire logic        subsys_load_valid,
  input  wire logic [31:0] subsys_load_data,
  input  wire logic        rom_present_pin,
  input  wire logic        rom_load_valid,
  input  wire logic [15:0] rom_load_data,
  input  wire logic        irq_tie_select,
  input  wire logic        irq_on_line_b,
  input  wire logic [31:0] pm_rdata,
  // Visible state
  output logic [7:0]       irq_route_byte,
  output logic [7:0]       irq_pin_code
);
  logic [31:0] subsys_r;
  logic [31:0] subsys_nxt;
  logic [7:0]  route_r;
  logic [7:0]  route_nxt;
  logic [7:0]  pin_r;
  logic [7:0]  pin_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        pmsel_r;
  logic        rom_present;
  logic [15:0] hints;
  logic [31:0] ext_base_word;
  logic [31:0] pm_capmap_word;
  logic [31:0] irq_word;
  logic [31:0] hc_word;
  logic        hit_ext;
  logic        hit_sub;
  logic        hit_cap;
  logic        hit_irq;
  logic        hit_hc;
  logic        hit_pm;
  logic        route_we;

  // Checks whether a dword address matches an offset
  function automatic logic dw_hit(input logic [7:0] a, input logic [7:0] off);
    dw_hit = (a[7:2] == off[7:2]);
  endfunction

  // ROM detect strap comes from a pin
  cfg_sync2 u_rom_sync
  (
    .mclk (mclk),
    .rst  (rst),
    .din  (rom_present_pin),
    .dout (rom_present)
  );

  cfg_hint_loader u_hints
  (
    .mclk           (mclk),
    .rst            (rst),
    .rom_present    (rom_present),
    .rom_load_valid (rom_load_valid),
    .rom_load_data  (rom_load_data),
    .hints          (hints)
  );

  // Address decode
  assign hit_ext = dw_hit(cfg_addr, cfg_tail_pkg::OFF_EXT_BASE);
  assign hit_sub = dw_hit(cfg_addr, cfg_tail_pkg::OFF_SUBSYS);
  assign hit_cap = dw_hit(cfg_addr, cfg_tail_pkg::OFF_CAP_PTR);
  assign hit_irq = dw_hit(cfg_addr, cfg_tail_pkg::OFF_IRQ_ROUTE);
  assign hit_hc  = dw_hit(cfg_addr, cfg_tail_pkg::OFF_HC_CONTROL);
  assign hit_pm  = dw_hit(cfg_addr, cfg_tail_pkg::OFF_PM_FIRST) | dw_hit(cfg_addr, cfg_tail_pkg::OFF_PM_SECOND);

  assign ext_base_word = cfg_tail_pkg::EXT_BASE_RST;

  assign pm_capmap_word = {24'h00_0000, cfg_tail_pkg::CAP_PTR_VAL};

  // Hints in upper half beside pin and route
  assign irq_word = {hints, pin_r, route_r};

  assign hc_word = {16'h0000, cfg_tail_pkg::HC_CTRL_VAL};

  // Only the route byte takes writes
  assign route_we  = cfg_wr & hit_irq & cfg_be[0];
  assign route_nxt = route_we ? cfg_wdata[7:0] : route_r;

  // Device ident high, vendor ident low
  assign subsys_nxt = subsys_load_valid ? subsys_load_data : subsys_r;

  assign pin_nxt = (irq_tie_select || !irq_on_line_b) ? cfg_tail_pkg::PIN_LINE_A : cfg_tail_pkg::PIN_LINE_B;

  // Read mux; unmapped offsets read zero
  assign rdata_nxt = hit_ext ? ext_base_word :
                     hit_sub ? subsys_r :
                     hit_cap ? pm_capmap_word :
                     hit_irq ? irq_word :
                     hit_hc  ? hc_word :
                     hit_pm  ? pm_rdata : 32'h0000_0000;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      route_r <= cfg_tail_pkg::IRQ_ROUTE_RST[7:0];
      pin_r   <= cfg_tail_pkg::IRQ_ROUTE_RST[15:8];
    end
    else
    begin
      route_r <= route_nxt;
      pin_r   <= pin_nxt;
    end
  end

  // Subsystem ident holder
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      subsys_r <= cfg_tail_pkg::SUBSYS_RST;
    else
      subsys_r <= subsys_nxt;
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      pmsel_r  <= 1'b0;
    end
    else
    begin
      rdata_r  <= cfg_rd ? rdata_nxt : 32'h0000_0000;
      rvalid_r <= cfg_rd;
      pmsel_r  <= (cfg_rd | cfg_wr) & hit_pm;
    end
  end

  assign cfg_rdata      = rdata_r;
  assign cfg_rvalid     = rvalid_r;
  assign pm_select      = pmsel_r;
  assign irq_route_byte = route_r;
  assign irq_pin_code   = pin_r;

  // Checks
  AST_ROUTE_STORE: assert property (@(posedge mclk) disable iff (rst)
    route_we |=> irq_route_byte == $past(cfg_wdata[7:0]))
    else $error("route byte not stored");
  AST_RO_WRITE: assert property (@(posedge mclk) disable iff (rst)
    (cfg_wr && hit_sub && !subsys_load_valid) |=> $stable(subsys_r))
    else $error("subsystem ident changed by config write");
  AST_EXT_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_ext) |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("extension base not zero");
  AST_CAP_PTR: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_cap) |=> cfg_rdata[7:0] == 8'h44)
    else $error("capability pointer wrong");
  AST_TIE_A: assert property (@(posedge mclk) disable iff (rst)
    irq_tie_select |=> irq_pin_code == 8'h01)
    else $error("tie did not force line A");
  AST_PIN_B: assert property (@(posedge mclk) disable iff (rst)
    (!irq_tie_select && irq_on_line_b) |=> irq_pin_code == 8'h02)
    else $error("pin code not line B");
  AST_HC_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_hc) |=> cfg_rdata == 32'h0000_0000)
    else $error("control word not zero");
  AST_SUBSYS_LOAD: assert property (@(posedge mclk) disable iff (rst)
    subsys_load_valid |=> subsys_r == $past(subsys_load_data))
    else $error("subsystem load lost");
  AST_HINT_DEF: assert property (@(posedge mclk) disable iff (rst)
    !rom_present |=> hints == $past(hints))
    else $error("hints changed without ROM");
  AST_PM_SEL: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_pm) |=> pm_select && cfg_rdata == $past(pm_rdata))
    else $error("PM window not forwarded");
  AST_RVALID_PULSE: assert property (@(posedge mclk) disable iff (rst)
    cfg_rd |=> cfg_rvalid)
    else $error("read answer strobe missing");
  AST_RVALID_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !cfg_rd |=> !cfg_rvalid)
    else $error("answer strobe without read");
  AST_IDLE_ZERO: assert property (@(posedge mclk) disable iff (rst)
    !cfg_rd |=> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  AST_SUB_READ: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_sub) |=> cfg_rdata == $past(subsys_r))
    else $error("subsystem word not returned");
  AST_SUB_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !subsys_load_valid |=> $stable(subsys_r))
    else $error("subsystem ident changed without load");
  AST_ROUTE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !route_we |=> $stable(route_r))
    else $error("route byte changed without write");
  AST_ROUTE_BE: assert property (@(posedge mclk) disable iff (rst)
    (cfg_wr && hit_irq && !cfg_be[0]) |=> $stable(irq_route_byte))
    else $error("route byte written without its enable");
  AST_IRQ_READ: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_irq) |=> cfg_rdata == {$past(hints), $past(pin_r), $past(route_r)})
    else $error("interrupt dword layout wrong");
  AST_PIN_A: assert property (@(posedge mclk) disable iff (rst)
    (!irq_tie_select && !irq_on_line_b) |=> irq_pin_code == 8'h01)
    else $error("pin code not line A");
  AST_PIN_LEGAL: assert property (@(posedge mclk) disable iff (rst)
    irq_pin_code == 8'h01 || irq_pin_code == 8'h02)
    else $error("pin code out of range");
  AST_HINT_LOAD: assert property (@(posedge mclk) disable iff (rst)
    (rom_present && rom_load_valid) |=> hints == $past(rom_load_data))
    else $error("ROM hint load lost");
  AST_HINT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !(rom_present && rom_load_valid) |=> $stable(hints))
    else $error("hints changed without ROM load");
  AST_EXT_SIZE: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_ext) |=> cfg_rdata[10:4] == 7'h00)
    else $error("extension size bits not zero");
  AST_EXT_PF: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_ext) |=> cfg_rdata[3] == 1'b0)
    else $error("extension prefetch bit set");
  AST_EXT_TYPE: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_ext) |=> cfg_rdata[2:1] == 2'b00)
    else $error("extension locate type not zero");
  AST_EXT_MEM: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_ext) |=> cfg_rdata[0] == 1'b0)
    else $error("extension space flag set");
  AST_CAP_HIGH: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && hit_cap) |=> cfg_rdata[31:8] == 24'h00_0000)
    else $error("capability word upper bytes not zero");
  AST_PM_WR_SEL: assert property (@(posedge mclk) disable iff (rst)
    (cfg_wr && hit_pm) |=> pm_select)
    else $error("PM window not selected on write");
  AST_PM_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !((cfg_rd || cfg_wr) && hit_pm) |=> !pm_select)
    else $error("PM window selected without access");
  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
    (cfg_rd && !(hit_ext || hit_sub || hit_cap || hit_irq || hit_hc || hit_pm)) |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

// [rtl/cfg_hint_loader.sv]
// Latency hint holder: serial ROM load or fixed default
`timescale 1ns/1ns
module cfg_hint_loader
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Loader side
  input  wire logic        rom_present,
  input  wire logic        rom_load_valid,
  input  wire logic [15:0] rom_load_data,
  // Current hints
  output logic [15:0]      hints
);
  logic [15:0] hints_r;
  logic [15:0] hints_nxt;

  // Only the loader updates; absent ROM keeps the default
  assign hints_nxt = (rom_present && rom_load_valid) ? rom_load_data : hints_r;

  // Default restored on every reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hints_r <= cfg_tail_pkg::LAT_HINTS_DEF;
    else
      hints_r <= hints_nxt;
  end

  assign hints = hints_r;
endmodule

// [rtl/cfg_sync2.sv]
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module cfg_sync2
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  logic hold_r;

  // First flop feeds only the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      hold_r <= meta_r;
    end
  end

  assign dout = hold_r;
endmodule

// [rtl/cfg_tail_pkg.sv]
// Constants for the configuration header tail register bank
package cfg_tail_pkg;
  // Doubleword offsets of the covered header words
  localparam logic [7:0] OFF_EXT_BASE   = 8'h14;
  localparam logic [7:0] OFF_SUBSYS     = 8'h2C;
  localparam logic [7:0] OFF_CAP_PTR    = 8'h34;
  localparam logic [7:0] OFF_IRQ_ROUTE  = 8'h3C;
  localparam logic [7:0] OFF_LAT_HINTS  = 8'h3E;
  localparam logic [7:0] OFF_HC_CONTROL = 8'h40;
  localparam logic [7:0] OFF_PM_FIRST   = 8'h44;
  localparam logic [7:0] OFF_PM_SECOND  = 8'h48;
  localparam logic [7:0] OFF_MISC_CFG   = 8'h80;
  // Field positions
  localparam int         IRQ_TIE_BIT    = 29;
  localparam int         PTR_LSB        = 11;
  // Reset and constant values
  localparam logic [31:0] EXT_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] SUBSYS_RST    = 32'h0000_0000;
  localparam logic [7:0]  CAP_PTR_VAL   = 8'h44;
  localparam logic [7:0]  ROUTE_RST     = 8'h00;
  localparam logic [7:0]  PIN_LINE_A    = 8'h01;
  localparam logic [7:0]  PIN_LINE_B    = 8'h02;
  localparam logic [15:0] IRQ_ROUTE_RST = 16'h0200;
  localparam logic [15:0] LAT_HINTS_DEF = 16'h0403;
  localparam logic [7:0]  MIN_GRANT_DEF = 8'h03;
  localparam logic [7:0]  ACC_INT_DEF   = 8'h04;
  localparam logic [15:0] HC_CTRL_VAL   = 16'h0000;
endpackage

// [sim/cfg_host_model.sv]
// Host model issuing configuration reads and writes
`timescale 1ns/1ns
module cfg_host_model
(
  // Clock
  input  wire logic        mclk,
  // Access request
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // Read answer
  input  wire logic [31:0] cfg_rdata
);
  // Idle bus at time zero
  initial
  begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] dat);
    @(negedge mclk);
    cfg_wr    = 1'b1;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = dat;
    @(negedge mclk);
    cfg_wr    = 1'b0;
    // Released lines flip so a stale value never passes for a live one
    cfg_addr  = ~a;
    cfg_be    = ~be;
    cfg_wdata = ~dat;
  endtask

  // Answer taken one cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(negedge mclk);
    cfg_rd   = 1'b1;
    cfg_addr = a;
    @(negedge mclk);
    cfg_rd   = 1'b0;
    cfg_addr = ~a;
    dat      = cfg_rdata;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the header tail register bank
`timescale 1ns/1ns
module tb_top;
  logic        mclk, rst = 1'b1, cfg_rd, cfg_wr, cfg_rvalid, pm_select;
  logic        subsys_load_valid = 1'b0, rom_present_pin = 1'b0, rom_load_valid = 1'b0;
  logic        irq_tie_select = 1'b0, irq_on_line_b = 1'b1;
  logic [3:0]  cfg_be;
  logic [7:0]  cfg_addr, irq_route_byte, irq_pin_code, route = 8'h00;
  logic [15:0] rom_load_data = 16'h0000;
  logic [31:0] cfg_wdata, cfg_rdata, d, r, subsys_load_data = '0, pm_rdata = '0, rng = 32'h18;
  logic [7:0]  ro_addr [5] = '{8'h14, 8'h2C, 8'h34, 8'h40, 8'h50};
  logic [31:0] ro_exp [5]  = '{32'h0, 32'h0, 32'h44, 32'h0, 32'h0};
  int          num_errors = 0, total_checks = 0;

  cfg_header_tail u_cfg_header_tail
  (
    .mclk, .rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .pm_select, .subsys_load_valid, .subsys_load_data, .rom_present_pin, .rom_load_valid,
    .rom_load_data, .irq_tie_select, .irq_on_line_b, .pm_rdata, .irq_route_byte, .irq_pin_code
  );
  cfg_host_model u_cfg_host_model
  (
    .mclk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata
  );

  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected dword 3Ch: hints, pin code, route byte
  function automatic logic [31:0] irq_word(input logic [15:0] h, input logic t, input logic b,
                                           input logic [7:0] rt);
    return {h, (t | !b) ? 8'h01 : 8'h02, rt};
  endfunction

  // Read one dword, check data and the answer strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    u_cfg_host_model.rd(a, d);
    chk(d, e);
    chk({31'h0, cfg_rvalid}, 32'h1);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 90 cycles the tests need
  initial
  begin
    #20000;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rchk(8'h3C, 32'h0403_0200);
    // Read-only words and an unmapped word ignore an all-ones write
    foreach (ro_addr[i])
    begin
      u_cfg_host_model.wr(ro_addr[i], 4'hF, 32'hFFFF_FFFF);
      rchk(ro_addr[i], ro_exp[i]);
    end
    $display("test read-only done");
    // Random byte enables: only byte 0 of 3Ch is stored
    repeat (8)
    begin
      r = rnd();
      u_cfg_host_model.wr(8'h3C, r[3:0], r);
      if (r[0])
        route = r[7:0];
      rchk(8'h3C, irq_word(16'h0403, 1'b0, 1'b1, route));
      chk({24'h0, irq_route_byte}, {24'h0, route});
    end
    $display("test route done");
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      {irq_tie_select, irq_on_line_b} = i[1:0];
      @(negedge mclk);
      r = irq_word(16'h0403, irq_tie_select, irq_on_line_b, route);
      chk({24'h0, irq_pin_code}, {24'h0, r[15:8]});
      rchk(8'h3C, r);
    end
    $display("test pin done");
    r = rnd();
    @(negedge mclk);
    subsys_load_data  = r;
    subsys_load_valid = 1'b1;
    @(negedge mclk);
    subsys_load_valid = 1'b0;
    subsys_load_data  = ~r;
    u_cfg_host_model.wr(8'h2C, 4'hF, ~r);
    rchk(8'h2C, r);
    $display("test subsystem done");
    for (int i = 0; i < 2; i++)
    begin
      pm_rdata = rnd();
      rchk(8'h44 + 8'(i * 4), pm_rdata);
      chk({31'h0, pm_select}, 32'h1);
    end
    $display("test power block done");
    @(negedge mclk);
    rom_present_pin = 1'b1;
    repeat (3) @(negedge mclk);
    r = rnd();
    rom_load_data  = r[15:0];
    rom_load_valid = 1'b1;
    @(negedge mclk);
    rom_load_valid = 1'b0;
    u_cfg_host_model.wr(8'h3C, 4'hC, 32'hFFFF_FFFF);
    rchk(8'h3C, irq_word(r[15:0], irq_tie_select, irq_on_line_b, route));
    $display("test rom hints done");
    conclude();
  end
endmodule
